// file: pkg/mode_switch_pkg.sv
// mode switch package: constants, states and carrier types
// assumes a core sequencer on the same clock drives all event strobes
package mode_switch_pkg;

  // ==========================================================
  // widths and field positions
  localparam int WORD_W   = 16;
  localparam int ADDR_W   = 20;
  localparam int MODE_BIT = 15;
  localparam int SEG_SHIFT = 4;
  localparam int VEC_SHIFT = 2;

  // ==========================================================
  // values after reset
  localparam logic [15:0] PSW_RST = 16'hF002;
  localparam logic [15:0] SEG_RST = 16'hFFFF;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [19:0] RESTART_ADDR = 20'hFFFF0;
  localparam logic        MODE_NATIVE  = 1'b1;
  localparam logic        MODE_EMUL    = 1'b0;
  localparam logic        WREN_RST     = 1'b0;

  // ==========================================================
  // sequencing states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_VEC  = 2'b10
  } seq_state_t;

  // one stack frame: status word, segment, counter
  typedef struct packed {
    logic [15:0] program_status_word;
    logic [15:0] seg;
    logic [15:0] pc;
  } frame_t;

  // vector fetched from the table
  typedef struct packed {
    logic [15:0] seg;
    logic [15:0] off;
  } vector_t;

endpackage

// file: design/cpu_mode_switch_control.sv
// mode flag control for native / emulation switching in the core
// assumes a sequencer on sys_clk that strobes decoded events one cycle
`timescale 1ns/1ps
module cpu_mode_switch_control
  import mode_switch_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // decoded events from sequencer, one-cycle strobes
  input  wire logic               enterEmulationBreak,
  input  wire logic               callNative,
  input  wire logic               returnFromEmulation,
  input  wire logic               returnFromInterrupt,
  input  wire logic               statusWordPop,
  input  wire logic               interruptEntry,
  input  wire logic [7:0]         vectorNumberOperand,
  // popped stack frame, valid with the pop events
  input  wire frame_t             popFrame,
  // ordinary counter update from the sequencer
  input  wire logic               pcLoad,
  input  wire logic [15:0]        pcValue,
  // vector table read
  output logic                    vecReq,
  output logic [ADDR_W-1:0]       vecAddr,
  input  wire logic               vecValid,
  input  wire vector_t            vecData,
  // frame push toward the stack
  output logic                    pushValid,
  output frame_t                  pushFrame,
  // bus cycle kind
  input  wire logic               refreshCycle,
  // core state
  output logic                    modeFlag,
  output logic                    modeWritable,
  output logic [15:0]             programStatusWord,
  output logic [15:0]             programSegment,
  output logic [15:0]             programCounter,
  output logic [ADDR_W-1:0]       fetchAddr,
  output logic                    legacyDecode,
  output logic                    useBasePointer,
  output logic                    processorStatusBit3,
  output logic                    busy
);

  // ==========================================================
  // state carrier
  typedef struct packed {
    seq_state_t        st;
    logic [15:0]       program_status_word;
    logic [15:0]       seg;
    logic [15:0]       pc;
    logic              wren;
    logic              newMode;
    logic              pushV;
    frame_t            pushF;
    logic              vReq;
    logic [ADDR_W-1:0] vAddr;
    logic [ADDR_W-1:0] fAddr;
    logic              ps3;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // physical address from segment and offset
  function automatic logic [ADDR_W-1:0] physAddr(input logic [15:0] seg,
                                                 input logic [15:0] off);
    physAddr = ({4'h0, seg} << SEG_SHIFT) + {4'h0, off};
  endfunction

  // vector table entry address
  function automatic logic [ADDR_W-1:0] vecLoc(input logic [7:0] num);
    vecLoc = {12'h000, num} << VEC_SHIFT;
  endfunction

  // status word restore honouring write protection of the flag
  function automatic logic [15:0] restorePsw(input logic [15:0] cur,
                                             input logic [15:0] popped,
                                             input logic        wr);
    restorePsw = popped;
    restorePsw[MODE_BIT] = wr ? popped[MODE_BIT] : cur[MODE_BIT];
  endfunction

  logic emul;
  logic takeBreak;
  logic takeCall;
  logic takeRetem;

  // ==========================================================
  // event qualification
  assign emul      = (s_reg.program_status_word[MODE_BIT] == MODE_EMUL);
  assign takeBreak = enterEmulationBreak & ~emul;
  assign takeCall  = callNative & emul;
  assign takeRetem = returnFromEmulation & emul;

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.pushV = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        // interrupt entry wins over instruction events
        if (interruptEntry) begin
          s_next.pushF = '{program_status_word: s_reg.program_status_word, seg: s_reg.seg, pc: s_reg.pc};
          s_next.newMode = MODE_NATIVE;
          s_next.vAddr = vecLoc(vectorNumberOperand);
          s_next.st = ST_PUSH;
        end else if (takeBreak) begin
          s_next.pushF = '{program_status_word: s_reg.program_status_word, seg: s_reg.seg, pc: s_reg.pc};
          s_next.newMode = MODE_EMUL;
          s_next.wren = 1'b1;
          s_next.vAddr = vecLoc(vectorNumberOperand);
          s_next.st = ST_PUSH;
        end else if (takeCall) begin
          // flag is zero here, so the stacked flag is zero
          s_next.pushF = '{program_status_word: s_reg.program_status_word, seg: s_reg.seg, pc: s_reg.pc};
          s_next.pushF.program_status_word[MODE_BIT] = MODE_EMUL;
          s_next.newMode = MODE_NATIVE;
          s_next.vAddr = vecLoc(vectorNumberOperand);
          s_next.st = ST_PUSH;
        end else if (takeRetem) begin
          // flag taken from the frame, then locked
          s_next.seg = popFrame.seg;
          s_next.pc  = popFrame.pc;
          s_next.program_status_word = popFrame.program_status_word;
          s_next.wren = 1'b0;
        end else if (returnFromInterrupt) begin
          // a locked flag keeps its value, even when nested
          s_next.seg = popFrame.seg;
          s_next.pc  = popFrame.pc;
          s_next.program_status_word = restorePsw(s_reg.program_status_word, popFrame.program_status_word,
                                  s_reg.wren);
        end else if (statusWordPop) begin
          s_next.program_status_word = restorePsw(s_reg.program_status_word, popFrame.program_status_word,
                                  s_reg.wren);
        end else if (pcLoad) begin
          s_next.pc = pcValue;
        end
      end
      ST_PUSH: begin
        // one-cycle push of the saved frame
        s_next.pushV = 1'b1;
        s_next.vReq = 1'b1;
        s_next.st = ST_VEC;
      end
      ST_VEC: begin
        // wait for vector, then switch mode and load segment
        if (vecValid) begin
          s_next.vReq = 1'b0;
          s_next.seg = vecData.seg;
          s_next.pc  = vecData.off;
          s_next.program_status_word[MODE_BIT] = s_reg.newMode;
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
        s_next.vReq = 1'b0;
      end
    endcase
    // fetch inside the 64 KB segment of the loaded segment
    s_next.fAddr = physAddr(s_next.seg, s_next.pc);
    // status bit3: high in emulation, else only on refresh
    s_next.ps3 = (s_next.program_status_word[MODE_BIT] == MODE_EMUL) | refreshCycle;
  end

  // state register, reset gives native restart
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg.st      <= ST_IDLE;
      s_reg.program_status_word     <= PSW_RST;
      s_reg.seg     <= SEG_RST;
      s_reg.pc      <= PC_RST;
      s_reg.wren    <= WREN_RST;
      s_reg.newMode <= MODE_NATIVE;
      s_reg.pushV   <= 1'b0;
      s_reg.pushF   <= '0;
      s_reg.vReq    <= 1'b0;
      s_reg.vAddr   <= '0;
      s_reg.fAddr   <= RESTART_ADDR;
      s_reg.ps3     <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign modeFlag            = s_reg.program_status_word[MODE_BIT];
  assign modeWritable        = s_reg.wren;
  assign programStatusWord   = s_reg.program_status_word;
  assign programSegment      = s_reg.seg;
  assign programCounter      = s_reg.pc;
  assign fetchAddr           = s_reg.fAddr;
  assign legacyDecode        = emul;
  assign useBasePointer      = emul;
  assign processorStatusBit3 = s_reg.ps3;
  assign pushValid           = s_reg.pushV;
  assign pushFrame           = s_reg.pushF;
  assign vecReq              = s_reg.vReq;
  assign vecAddr             = s_reg.vAddr;
  assign busy                = (s_reg.st != ST_IDLE);

endmodule

// file: dv/mode_switch_props.sv
// checker for the mode flag control: flag, decode and status relations
// assumes a bind onto the mode switch control block, one clock domain
`timescale 1ns/1ps
module mode_switch_props
  import mode_switch_pkg::*;
(
  // clock, reset and sequencer events
  input wire logic              sys_clk, sys_rst, refreshCycle,
  input wire logic              enterEmulationBreak, callNative,
  input wire logic              returnFromEmulation, returnFromInterrupt,
  input wire logic              statusWordPop, interruptEntry,
  input wire logic [7:0]        vectorNumberOperand,
  // observed core state
  input wire logic              busy, modeFlag, modeWritable, pushValid,
  input wire logic              legacyDecode, useBasePointer,
  input wire logic              processorStatusBit3,
  input wire logic [15:0]       programStatusWord,
  input wire logic [ADDR_W-1:0] vecAddr, fetchAddr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // accepted events
  wire logic hiEv = interruptEntry || enterEmulationBreak || callNative;
  wire logic brkOk = enterEmulationBreak && !interruptEntry && !busy
                     && modeFlag;
  wire logic retemOk = returnFromEmulation && !hiEv && !busy && !modeFlag;
  wire logic retiLk = returnFromInterrupt && !hiEv && !returnFromEmulation
                      && !busy && !modeWritable;
  // ==========================================================
  // assertions
  flag_top_bit_a: assert property (modeFlag == programStatusWord[15])
    else $error("mode flag differs from status word top bit");
  decode_sel_a: assert property ((legacyDecode == !modeFlag)
    && (useBasePointer == !modeFlag)) else $error("decode or stack select");
  brk_unlock_a: assert property (brkOk |=> modeWritable ##1 pushValid)
    else $error("break did not unlock and push");
  brk_vector_a: assert property (brkOk |=>
    vecAddr == {10'h000, $past(vectorNumberOperand), 2'h0})
    else $error("break vector address wrong");
  return_from_emulation_lock_a: assert property (retemOk |=> !modeWritable)
    else $error("return from emulation left flag writable");
  return_from_interrupt_locked_a: assert property (retiLk |=> $stable(modeFlag))
    else $error("locked flag changed on return");
  native_cause_a: assert property ($rose(modeFlag) |-> $past(busy)
    || $past(returnFromEmulation) || $past(returnFromInterrupt)
    || $past(statusWordPop)) else $error("emulation left without cause");
  status_bit_a: assert property (!$past(sys_rst) |->
    processorStatusBit3 == (!modeFlag || $past(refreshCycle)))
    else $error("status bit3 wrong");
  reset_native_a: assert property ($fell(sys_rst) |-> modeFlag
    && fetchAddr == RESTART_ADDR) else $error("reset state wrong");
  // main scenarios
  cover property (brkOk ##1 modeWritable);
  cover property (callNative && !modeFlag && !busy);
  cover property (retemOk);
endmodule

// file: dv/tb_cpu_mode_switch_control.sv
// self-checking bench for the mode flag control block
// assumes the package and the design are compiled first
`timescale 1ns/1ps
module tb_cpu_mode_switch_control import mode_switch_pkg::*; ;
  logic             sys_clk = 1'h0, sys_rst = 1'h1;
  logic             refreshCycle = 1'h0, vecValid = 1'h0;
  logic [5:0]       ev = 6'h00;
  logic [7:0]       vno = 8'h00;
  frame_t           pf = '0, sv;
  vector_t          vd = '0;
  wire logic        vecReq, pushValid, modeFlag, modeWritable, busy;
  wire logic        legacyDecode, useBasePointer, processorStatusBit3;
  wire frame_t      pushFrame;
  wire logic [15:0] programStatusWord, programSegment, programCounter;
  wire logic [ADDR_W-1:0] vecAddr, fetchAddr;
  int               n_mismatch = 0, checks = 0;
  cpu_mode_switch_control cpu_mode_switch_control_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .interruptEntry(ev[0]),
    .enterEmulationBreak(ev[1]), .callNative(ev[2]),
    .returnFromEmulation(ev[3]), .returnFromInterrupt(ev[4]),
    .statusWordPop(ev[5]), .vectorNumberOperand(vno), .popFrame(pf),
    .pcLoad(1'h0), .pcValue(16'h0000), .vecReq(vecReq), .vecAddr(vecAddr),
    .vecValid(vecValid), .vecData(vd), .pushValid(pushValid),
    .pushFrame(pushFrame), .refreshCycle(refreshCycle),
    .modeFlag(modeFlag), .modeWritable(modeWritable),
    .programStatusWord(programStatusWord), .programSegment(programSegment),
    .programCounter(programCounter), .fetchAddr(fetchAddr),
    .legacyDecode(legacyDecode), .useBasePointer(useBasePointer),
    .processorStatusBit3(processorStatusBit3), .busy(busy));
  // ==========================================================
  // clock and shared tasks
  initial forever #5 sys_clk = ~sys_clk;
  task automatic ck(input bit ok, input string m);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic go(input int k, input logic [7:0] n);
    @(negedge sys_clk);
    ev[k] = 1'h1;
    vno = n;
    @(negedge sys_clk);
    ev = 6'h00;
  endtask
  task automatic ret(input int k, input logic [15:0] program_status_word);
    pf = {program_status_word, 16'h1234, 16'h0040};
    go(k, 8'h00);
    @(negedge sys_clk);
  endtask
  task automatic ent(input int k, input logic [7:0] n, input vector_t v,
                     input logic f);
    go(k, n);
    for (int i = 0; i < 9 && pushValid !== 1'h1; i++) @(negedge sys_clk);
    ck(pushValid === 1'h1, "no frame push");
    sv = pushFrame;
    ck(vecAddr === {10'h000, n, 2'h0}, "vector address");
    vd = v;
    vecValid = 1'h1;
    for (int i = 0; i < 9 && vecReq === 1'h1; i++) @(negedge sys_clk);
    vecValid = 1'h0;
    for (int i = 0; i < 9 && busy !== 1'h0; i++) @(negedge sys_clk);
    ck(modeFlag === f && programSegment === v.seg, "entry flag");
    ck(fetchAddr === {v.seg, 4'h0} + v.off, "fetch address");
    ck(programCounter === v.off, "entry counter");
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    ck(programStatusWord === PSW_RST && modeFlag === 1'h1, "reset");
    ck(fetchAddr === RESTART_ADDR && modeWritable === 1'h0, "start");
    refreshCycle = 1'h1;
    @(negedge sys_clk);
    refreshCycle = 1'h0;
    ck(processorStatusBit3 === 1'h1, "refresh status bit");
  endtask
  task automatic t_refuse;
    go(2, 8'h08);
    go(3, 8'h08);
    ck(busy === 1'h0 && modeFlag === 1'h1, "native refusal");
  endtask
  task automatic t_break;
    ent(1, 8'h05, {16'h2000, 16'h0100}, 1'h0);
    ck(sv === {PSW_RST, SEG_RST, PC_RST}, "break frame");
    ck(legacyDecode === 1'h1 && useBasePointer === 1'h1, "emul");
    ck(modeWritable === 1'h1, "break unlock");
    ck(processorStatusBit3 === 1'h1, "status bit in emulation");
    go(1, 8'h07);
    ck(busy === 1'h0 && modeFlag === 1'h0, "break in emulation");
  endtask
  task automatic t_call;
    ent(2, 8'h09, {16'h3000, 16'h0020}, 1'h1);
    ck(sv.program_status_word[15] === 1'h0, "call stacks zero flag");
    ret(4, 16'h7002);
    ck(modeFlag === 1'h0 && legacyDecode === 1'h1, "return_from_interrupt resume");
  endtask
  task automatic t_irq;
    ent(0, 8'h02, {16'h4000, 16'h0008}, 1'h1);
    ck(useBasePointer === 1'h0, "native stack");
    ret(4, 16'h7002);
    ck(modeFlag === 1'h0, "irq return resumes emulation");
  endtask
  task automatic t_return_from_emulation;
    ret(3, PSW_RST);
    ck(modeFlag === 1'h1 && modeWritable === 1'h0, "return_from_emulation");
    ret(5, 16'h7002);
    ret(4, 16'h7002);
    ck(modeFlag === 1'h1, "locked flag kept");
  endtask
  task automatic t_rst_emul;
    ent(1, 8'h01, {16'h5000, 16'h0000}, 1'h0);
    sys_rst = 1'h1;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'h0;
    ck(modeFlag === 1'h1 && fetchAddr === RESTART_ADDR, "reset exit");
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence after a three-cycle reset
  // no break is issued inside a native routine entered from emulation
  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'h0;
    t_reset;
    t_refuse;
    t_break;
    t_call;
    t_irq;
    t_return_from_emulation;
    t_rst_emul;
    end_sim;
  end
  // watchdog well beyond the roughly 45 cycles used
  initial begin
    #50000;
    n_mismatch++;
    end_sim;
  end
endmodule
bind cpu_mode_switch_control mode_switch_props mode_switch_props_inst (.*);
